// file: pkg/endpoint_b_cfg.svh
// constants for the endpoint b control block
// assumes inclusion by the package and the design file only
`ifndef ENDPOINT_B_CFG_SVH
`define ENDPOINT_B_CFG_SVH
`define EPB_OFS_DESC 32'hfff06064
`define EPB_OFS_CTRL 32'hfff06068
`define EPB_OFS_IEN 32'hfff0606c
`define EPB_OFS_ICLR 32'hfff06070
`define EPB_OFS_ISTAT 32'hfff06074
`define EPB_OFS_ADDR 32'hfff06078
`define EPB_OFS_LEN 32'hfff0607c
`define EPB_RESET_VAL 32'h00000000
`define EPB_KIND_HI 30
`define EPB_KIND_LO 29
`define TRANSFER_DIRECTION_BIT 28
`define MAX_PACKET_BYTES_HI 25
`define MAX_PACKET_BYTES_LO 16
`define ALTERNATE_SETTING_HI 15
`define ALTERNATE_SETTING_LO 12
`define INTERFACE_INDEX_HI 11
`define INTERFACE_INDEX_LO 8
`define CONFIGURATION_INDEX_HI 7
`define CONFIGURATION_INDEX_LO 4
`define ENDPOINT_NUMBER_HI 3
`define ENDPOINT_NUMBER_LO 0
`define ENDPOINT_CONTROL_ZERO 6
`define ENDPOINT_CONTROL_STLCLR 5
`define ENDPOINT_CONTROL_THRE 4
`define ENDPOINT_CONTROL_STL 3
`define ENDPOINT_CONTROL_RDY 2
`define ENDPOINT_CONTROL_FLUSH 1
`define ENDPOINT_CONTROL_ACT 0
`define EPB_EV_CF 5
`define EPB_EV_BUSERR 4
`define EPB_EV_DMA 3
`define EPB_EV_ALT 2
`define EPB_EV_TOKEN 1
`define EPB_EV_STALL 0
`define EPB_EV_W 6
`define EPB_LEN_W 20
`define EPB_THR_LOW 11'h010
`define EPB_THR_HIGH 11'h020
`define EPB_KIND_ISO 2'h3
`endif

// file: pkg/endpoint_b_pkg.sv
// types shared by the endpoint b control block
// assumes the cfg header sits beside it on the include path
`include "endpoint_b_cfg.svh"
package endpoint_b_pkg;
  typedef struct packed {
    logic [3:0] endpointNumber;
    logic [3:0] configurationIndex;
    logic [3:0] interfaceIndex;
  } host_select_t;
  typedef struct packed {
    logic cf;
    logic busError;
    logic dmaDone;
    logic altSetting;
    logic token;
    logic stall;
  } events_t;
  typedef enum logic [1:0] {KIND_RSVD, KIND_BULK, KIND_INTR, KIND_ISO}
    transfer_kind_t;
endpackage : endpoint_b_pkg

// file: verilog/usb_endpoint_b_control.sv
// endpoint b descriptor, control and event registers on avalon-mm
// assumes usb engine and dma engine on clk give one-cycle event pulses
// Contract
// - kind at 30:29, direction at 28
// - ten-bit max packet size at 25:16
// - alternate setting read-only, set by device
// - zero-length bit sends empty packet
// - write-one bit 5 releases stall, unreadable
// - iso dma threshold 16 or 32 free
// - control bit 3 stalls endpoint
// - enable bit 5 gates clear-feature event
// - enable bit 4 gates bus error
// - enable bit 3 gates dma done
// - enable bit 2 gates alternate setting
// - enable bit 1 gates token event
// - enable bit 0 gates stall event
// - clear register write-one-to-clear, write-only
// - clears touch only their own bits
// - status register shows pending events
`timescale 1ns/100ps
`default_nettype none
`include "endpoint_b_cfg.svh"
module usb_endpoint_b_control
  import endpoint_b_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  input wire host_select_t hostSelect,
  input wire logic altUpdate,
  input wire logic [3:0] altValue,
  input wire events_t eventIn,
  input wire logic [10:0] fifoFree,
  output logic endpointSelected,
  output logic stallActive,
  output logic zeroLengthSend,
  output logic dmaStart,
  output logic dmaGranted,
  output logic flushPulse,
  output logic [31:0] xferAddress,
  output logic [19:0] xferLength,
  output logic [1:0] transferKind,
  output logic transferDirection,
  output logic [9:0] maxPacketBytes,
  output logic eventPending
);
  logic [31:0] desc_reg;
  logic [6:0] ctrl_reg;
  logic [`EPB_EV_W-1:0] ien_reg;
  logic [`EPB_EV_W-1:0] stat_reg;
  logic [`EPB_EV_W-1:0] eventBits;
  logic [`EPB_EV_W-1:0] gatedEvents;
  logic descWr;
  logic ctrlWr;
  logic ienWr;
  logic iclrWr;
  logic addrWr;
  logic lenWr;
  logic [31:0] addr_reg;
  logic [`EPB_LEN_W-1:0] len_reg;
  logic stall_reg;
  logic ack_reg;
  logic flush_reg;
  logic [31:0] wmask;
  logic req;
  logic mapped;
  logic wrHit;
  logic [31:0] rdMux;

  // one wait cycle per access keeps read data registered
  assign req = (read | write) & ~ack_reg;
  assign waitrequest = (read | write) & ~ack_reg;
  assign wrHit = write & ack_reg;
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};

  // one decoded strobe per writable register, high only on the accepting edge
  assign descWr = wrHit && address == `EPB_OFS_DESC;
  assign ctrlWr = wrHit && address == `EPB_OFS_CTRL && byteenable[0];
  assign ienWr = wrHit && address == `EPB_OFS_IEN && byteenable[0];
  assign iclrWr = wrHit && address == `EPB_OFS_ICLR && byteenable[0];
  assign addrWr = wrHit && address == `EPB_OFS_ADDR;
  assign lenWr = wrHit && address == `EPB_OFS_LEN;
  assign eventBits = eventIn;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdMux = `EPB_RESET_VAL;
    unique case (address)
      `EPB_OFS_DESC: rdMux = desc_reg;
      // stall release bit is never stored, so it reads zero
      `EPB_OFS_CTRL: rdMux = {25'h0, ctrl_reg};
      `EPB_OFS_IEN: rdMux = {26'h0, ien_reg};
      `EPB_OFS_ICLR: rdMux = `EPB_RESET_VAL;
      `EPB_OFS_ISTAT: rdMux = {26'h0, stat_reg};
      `EPB_OFS_ADDR: rdMux = addr_reg;
      `EPB_OFS_LEN: rdMux = {12'h000, len_reg};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata <= `EPB_RESET_VAL;
      response <= 2'h0;
    end else if (req) begin
      readdata <= read ? rdMux : `EPB_RESET_VAL;
      // unmapped addresses answer decode error
      response <= mapped ? 2'h0 : 2'h3;
    end
  end

  // descriptor: reserved bits 31, 27:26 stay zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      desc_reg <= `EPB_RESET_VAL;
    end else begin
      if (descWr) begin
        desc_reg[`EPB_KIND_HI:`EPB_KIND_LO] <=
          (writedata[`EPB_KIND_HI:`EPB_KIND_LO] &
           wmask[`EPB_KIND_HI:`EPB_KIND_LO]) |
          (desc_reg[`EPB_KIND_HI:`EPB_KIND_LO] &
           ~wmask[`EPB_KIND_HI:`EPB_KIND_LO]);
        if (wmask[`TRANSFER_DIRECTION_BIT]) begin
          desc_reg[`TRANSFER_DIRECTION_BIT] <= writedata[`TRANSFER_DIRECTION_BIT];
        end
        desc_reg[`MAX_PACKET_BYTES_HI:`MAX_PACKET_BYTES_LO] <=
          (writedata[`MAX_PACKET_BYTES_HI:`MAX_PACKET_BYTES_LO] &
           wmask[`MAX_PACKET_BYTES_HI:`MAX_PACKET_BYTES_LO]) |
          (desc_reg[`MAX_PACKET_BYTES_HI:`MAX_PACKET_BYTES_LO] &
           ~wmask[`MAX_PACKET_BYTES_HI:`MAX_PACKET_BYTES_LO]);
        desc_reg[`INTERFACE_INDEX_HI:`ENDPOINT_NUMBER_LO] <=
          (writedata[`INTERFACE_INDEX_HI:`ENDPOINT_NUMBER_LO] &
           wmask[`INTERFACE_INDEX_HI:`ENDPOINT_NUMBER_LO]) |
          (desc_reg[`INTERFACE_INDEX_HI:`ENDPOINT_NUMBER_LO] &
           ~wmask[`INTERFACE_INDEX_HI:`ENDPOINT_NUMBER_LO]);
      end
      // only the host alternate-setting update writes this field; software descriptor writes never reach it
      if (altUpdate) begin
        desc_reg[`ALTERNATE_SETTING_HI:`ALTERNATE_SETTING_LO] <= altValue;
      end
    end
  end

  // control bits 6:0; bit 5 is a command, not state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= 7'h00;
    end else if (ctrlWr) begin
      ctrl_reg <= writedata[6:0] & 7'h5f;
    end
  end

  // stall condition: set by bit 3 write, released by write-one to bit 5
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stall_reg <= 1'b0;
    end else if (ctrlWr) begin
      if (writedata[`ENDPOINT_CONTROL_STLCLR]) begin
        stall_reg <= 1'b0;
      end else if (writedata[`ENDPOINT_CONTROL_STL]) begin
        stall_reg <= 1'b1;
      end
    end
  end

  // flush is a one-cycle pulse on each write of bit 1
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flush_reg <= 1'b0;
    end else begin
      flush_reg <= ctrlWr && writedata[`ENDPOINT_CONTROL_FLUSH];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ien_reg <= 6'h00;
    end else if (ienWr) begin
      ien_reg <= writedata[`EPB_EV_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_reg <= `EPB_RESET_VAL;
    end else if (addrWr) begin
      addr_reg <= (writedata & wmask) | (addr_reg & ~wmask);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      len_reg <= 20'h00000;
    end else if (lenWr) begin
      len_reg <= (writedata[`EPB_LEN_W-1:0] & wmask[`EPB_LEN_W-1:0]) |
                 (len_reg & ~wmask[`EPB_LEN_W-1:0]);
    end
  end

  // pending events: a new event beats a clear in the same cycle
  genvar evIdx;
  generate
    for (evIdx = 0; evIdx < `EPB_EV_W; evIdx++) begin : g_event
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          stat_reg[evIdx] <= 1'b0;
        end else if (eventBits[evIdx]) begin
          stat_reg[evIdx] <= 1'b1;
        end else if (iclrWr && writedata[evIdx]) begin
          stat_reg[evIdx] <= 1'b0;
        end
      end
      // a source reaches the pending output only through its enable
      assign gatedEvents[evIdx] = stat_reg[evIdx] & ien_reg[evIdx];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eventPending <= 1'b0;
    end else begin
      eventPending <= |gatedEvents;
    end
  end

  assign transferKind = desc_reg[`EPB_KIND_HI:`EPB_KIND_LO];
  assign transferDirection = desc_reg[`TRANSFER_DIRECTION_BIT];
  assign maxPacketBytes = desc_reg[`MAX_PACKET_BYTES_HI:`MAX_PACKET_BYTES_LO];
  assign xferAddress = addr_reg;
  assign xferLength = len_reg;
  assign flushPulse = flush_reg;
  assign stallActive = stall_reg;
  assign endpointSelected = ctrl_reg[`ENDPOINT_CONTROL_ACT] &&
    hostSelect.endpointNumber == desc_reg[`ENDPOINT_NUMBER_HI:`ENDPOINT_NUMBER_LO] &&
    hostSelect.configurationIndex == desc_reg[`CONFIGURATION_INDEX_HI:`CONFIGURATION_INDEX_LO] &&
    hostSelect.interfaceIndex == desc_reg[`INTERFACE_INDEX_HI:`INTERFACE_INDEX_LO];
  assign zeroLengthSend = ctrl_reg[`ENDPOINT_CONTROL_ZERO] && endpointSelected;
  // dma may only touch memory once software marked it ready
  assign dmaGranted = ctrl_reg[`ENDPOINT_CONTROL_RDY] && !flush_reg;
  // non-iso endpoints start dma whenever dma is granted
  assign dmaStart = dmaGranted &&
    (transferKind != `EPB_KIND_ISO ||
     fifoFree > (ctrl_reg[`ENDPOINT_CONTROL_THRE] ? `EPB_THR_LOW
                                         : `EPB_THR_HIGH));
endmodule : usb_endpoint_b_control
`default_nettype wire

// file: verif/usb_endpoint_b_control_props.sv
// port assertions for the endpoint b control block
// assumes it is bound into usb_endpoint_b_control
`timescale 1ns/100ps
`default_nettype none
module epb_props
  import endpoint_b_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic write,
  input wire logic waitrequest,
  input wire events_t eventIn,
  input wire logic [10:0] fifoFree,
  input wire logic flushPulse,
  input wire logic stallActive,
  input wire logic zeroLengthSend,
  input wire logic endpointSelected,
  input wire logic dmaStart,
  input wire logic dmaGranted,
  input wire logic [1:0] transferKind,
  input wire logic [9:0] maxPacketBytes,
  input wire logic eventPending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_ZERO: assert property (zeroLengthSend |-> endpointSelected)
    else $error("empty packet while unselected");
  AST_DMA_RDY: assert property (dmaStart |-> dmaGranted)
    else $error("dma start without ready");
  AST_ISO: assert property (dmaStart && transferKind == 2'h3
    |-> fifoFree > 11'h010) else $error("iso dma below threshold");
  AST_FLUSH: assert property (flushPulse |=> !flushPulse)
    else $error("flush longer than one cycle");
  AST_FLUSH_DMA: assert property (flushPulse |-> !dmaGranted)
    else $error("dma granted during flush");
  AST_PEND: assert property ($rose(eventPending)
    |-> $past(eventIn, 2) != '0 || $past(write, 2))
    else $error("pending without cause");
  AST_STL_SET: assert property ($rose(stallActive)
    |-> $past(write) && !$past(waitrequest)) else $error("stall without write");
  AST_STL_CLR: assert property ($fell(stallActive)
    |-> $past(write) && !$past(waitrequest)) else $error("stall lost");
  AST_MPS: assert property (!$past(write)
    |-> $stable(maxPacketBytes) && $stable(transferKind))
    else $error("descriptor changed without write");
endmodule : epb_props
bind usb_endpoint_b_control epb_props chk (.clk, .reset_n, .write,
  .waitrequest, .eventIn, .fifoFree, .flushPulse, .stallActive,
  .zeroLengthSend, .endpointSelected, .dmaStart, .dmaGranted,
  .transferKind, .maxPacketBytes, .eventPending);
`default_nettype wire

// file: verif/usb_host_model.sv
// host side stand-in: endpoint selection, alternate setting, events
// assumes its tasks are called from the clk domain
`timescale 1ns/100ps
`default_nettype none
module usb_host_model
  import endpoint_b_pkg::*;
(
  input wire logic clk,
  output var host_select_t hostSelect,
  output var logic altUpdate,
  output var logic [3:0] altValue,
  output var events_t eventIn
);
  initial begin
    hostSelect = '0;
    altUpdate = 1'b0;
    altValue = 4'h0;
    eventIn = '0;
  end
  task automatic pick(input host_select_t s);
    @(posedge clk);
    hostSelect <= s;
  endtask : pick
  task automatic alt(input logic [3:0] v);
    @(posedge clk);
    altUpdate <= 1'b1;
    altValue <= v;
    @(posedge clk);
    altUpdate <= 1'b0;
    // stale value must not look valid once the pulse is gone
    altValue <= ~v;
  endtask : alt
  task automatic fire(input events_t e);
    @(posedge clk);
    eventIn <= e;
    @(posedge clk);
    eventIn <= '0;
  endtask : fire
endmodule : usb_host_model
`default_nettype wire

// file: verif/usb_endpoint_b_control_tb_top.sv
// self-checking bench for the endpoint b control registers
// assumes package, design, checker and host model compiled first
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_b_control_tb_top;
  import endpoint_b_pkg::*;
  localparam logic [31:0] B = 32'hfff06064;
  logic clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
  logic [31:0] address = '0, writedata = '0, readdata, xferAddress, q;
  logic [19:0] xferLength;
  logic [1:0] response, transferKind, rs;
  logic [10:0] fifoFree = '0;
  logic [3:0] byteenable = 4'hf;
  logic [9:0] maxPacketBytes;
  logic [3:0] altValue;
  logic waitrequest, altUpdate, endpointSelected, stallActive;
  logic zeroLengthSend, dmaStart, dmaGranted, flushPulse;
  logic transferDirection, eventPending;
  host_select_t hostSelect;
  events_t eventIn;
  int errCount = 0, compares = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  usb_host_model host (.*);
  usb_endpoint_b_control dut (.*);
  task automatic endOfTest;
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : endOfTest
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errCount++;
      endOfTest();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      errCount++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // request holds until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    rs = response;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic rd(input logic [31:0] a, e, input logic [1:0] r = 2'h0);
    bus(1'b0, a, '0);
    chk(q, e);
    chk(32'(rs), 32'(r));
  endtask : rd
  task automatic ff(input int v, input logic e);
    @(posedge clk);
    fifoFree <= 11'(v);
    @(negedge clk);
    chk(32'(dmaStart), 32'(e));
  endtask : ff
  task automatic regs;
    for (int i = 0; i < 7; i++) rd(B + 4 * i, '0);
    rd(B + 28, '0, 2'h3);
    bus(1'b1, B, '1);
    rd(B, 32'h73ff0fff);
    chk(32'({transferKind, transferDirection, maxPacketBytes}), 32'h1fff);
    host.alt(4'h5);
    rd(B, 32'h73ff5fff);
    bus(1'b1, B + 24, '1);
    rd(B + 24, 32'h000fffff);
    chk(32'(xferLength), 32'hfffff);
    bus(1'b1, B + 20, 32'h89abcdef);
    rd(B + 20, 32'h89abcdef);
    chk(xferAddress, 32'h89abcdef);
    // control lanes need byte 0; a write without it must not land
    byteenable <= 4'he;
    bus(1'b1, B + 4, 32'h7f);
    byteenable <= 4'hf;
    rd(B + 4, 32'h0);
    chk(32'(stallActive), 0);
    $display("register test done");
  endtask : regs
  task automatic ctrl;
    host.pick(12'hfff);
    bus(1'b1, B + 4, 32'h5d);
    rd(B + 4, 32'h5d);
    chk({endpointSelected, zeroLengthSend, stallActive}, 3'h7);
    host.pick(12'hffe);
    @(negedge clk);
    chk(32'(endpointSelected), 0);
    bus(1'b1, B + 4, 32'h35);
    rd(B + 4, 32'h15);
    chk(32'(stallActive), 0);
    ff(16, 0);
    ff(17, 1);
    bus(1'b1, B + 4, 32'h05);
    ff(32, 0);
    ff(33, 1);
    bus(1'b1, B + 4, 32'h07);
    @(negedge clk);
    chk({flushPulse, dmaGranted}, 2'h2);
    bus(1'b1, B + 4, 32'h01);
    @(negedge clk);
    chk(32'(dmaGranted), 0);
    $display("control test done");
  endtask : ctrl
  task automatic events;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, B + 8, '0);
      host.fire(6'h3f);
      repeat (2) @(negedge clk);
      chk(32'(eventPending), 0);
      bus(1'b1, B + 8, 32'h1 << i);
      repeat (2) @(negedge clk);
      chk(32'(eventPending), 1);
      bus(1'b1, B + 12, 32'h1 << i);
      rd(B + 16, 32'h3f ^ (32'h1 << i));
      chk(32'(eventPending), 0);
      bus(1'b1, B + 12, 32'h3f);
    end
    $display("event test done");
  endtask : events
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    regs();
    ctrl();
    events();
    endOfTest();
  end
endmodule : usb_endpoint_b_control_tb_top
`default_nettype wire
